// ---- dnconv_pkg.sv ----
// Shared constants, register map and types of the down converter
package dnconv_pkg;
  localparam int IN_W = 16;
  localparam int DATA_W = 20;
  localparam int ADDR_W = 4;
  localparam int FREQ_W = 32;
  localparam int LUT_W = 16;

  localparam logic [ADDR_W-1:0] OFF_CTRL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_FREQ = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_FREQ_ACT = 4'hc;

  localparam int CTRL_EN = 0;
  localparam int CTRL_REAL = 1;
  localparam int CTRL_DEC_LSB = 2;
  localparam int CTRL_GAIN = 5;
  localparam int CTRL_FS4 = 6;
  localparam int CTRL_SWAP = 7;
  localparam int CTRL_INV = 8;
  localparam int CTRL_RESTART = 9;
  localparam logic [31:0] CTRL_MASK = 32'h0000_03ff;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] FREQ_RESET = 32'h0000_0000;

  localparam int ST_OVF = 0;
  localparam int ST_PEND = 1;
  localparam int ST_FULL = 2;
  localparam int ST_RUN = 3;

  localparam logic [2:0] DEC_MAX_CODE = 3'h4;

  // Quarter sine wave, 16 steps per quadrant, amplitude 32767
  localparam logic [LUT_W-1:0] SIN_Q [17] = '{
    16'h0000, 16'h0c8c, 16'h18f9, 16'h2528, 16'h30fb, 16'h3c56,
    16'h471c, 16'h5133, 16'h5a82, 16'h62f1, 16'h6a6d, 16'h70e2,
    16'h7641, 16'h7a7c, 16'h7d89, 16'h7f61, 16'h7fff};

  typedef enum logic [1:0] {
    DN_BYPASS = 2'b00,
    DN_COMPLEX = 2'b01,
    DN_REAL = 2'b10,
    DN_FS4 = 2'b11
  } dnconv_mode_t;
endpackage

// ---- dnconv_if.sv ----
// Valid/ready word stream between the converter core and its buffer
`timescale 1ns/100ps
interface dnconv_if #(parameter int W = 8);
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface

// ---- dnconv_nco.sv ----
// Oscillator: phase accumulator and sine/cosine lookup
`timescale 1ns/100ps
module dnconv_nco (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic step,
  input wire logic restart,
  input wire logic invert,
  input wire logic [dnconv_pkg::FREQ_W-1:0] freq_new,
  // Results
  output logic [dnconv_pkg::FREQ_W-1:0] freq_act,
  output logic signed [dnconv_pkg::LUT_W-1:0] cos_out,
  output logic signed [dnconv_pkg::LUT_W-1:0] sin_out
);
  import dnconv_pkg::*;

  logic [FREQ_W-1:0] phase_reg;
  logic [FREQ_W-1:0] freq_reg;

  function automatic logic signed [LUT_W-1:0] sin6(input logic [5:0] p);
    logic [LUT_W-1:0] mag;
    mag = p[4] ? SIN_Q[5'h10 - {1'b0, p[3:0]}] : SIN_Q[{1'b0, p[3:0]}];
    return p[5] ? -$signed(mag) : $signed(mag);
  endfunction

  wire logic [5:0] ph_top = phase_reg[FREQ_W-1 -: 6];
  wire logic signed [LUT_W-1:0] sin_raw = sin6(ph_top);

  assign cos_out = sin6(ph_top + 6'h10);
  assign sin_out = invert ? -sin_raw : sin_raw;
  assign freq_act = freq_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= '0;
      freq_reg <= FREQ_RESET;
    end else if (restart) begin
      phase_reg <= '0;
      freq_reg <= freq_new;
    end else if (step) begin
      phase_reg <= phase_reg + freq_reg;
    end
  end
endmodule // dnconv_nco

// ---- dnconv_buf.sv ----
// Two-entry stream buffer; both outgoing words and flags come from flip-flops
`timescale 1ns/100ps
module dnconv_buf #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Streams
  dnconv_if.snk s,
  dnconv_if.src m
);
  logic [W-1:0] out_reg;
  logic [W-1:0] spare_reg;
  logic out_v_reg;
  logic spare_v_reg;

  wire logic take = s.valid & ~spare_v_reg;
  wire logic give = out_v_reg & m.ready;
  wire logic load = ~out_v_reg | give;

  assign s.ready = ~spare_v_reg;
  assign m.valid = out_v_reg;
  assign m.data = out_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= '0;
      spare_reg <= '0;
      out_v_reg <= 1'b0;
      spare_v_reg <= 1'b0;
    end else begin
      if (load) begin
        out_v_reg <= spare_v_reg | take;
        out_reg <= spare_v_reg ? spare_reg : s.data;
      end
      if (take & ~load) begin
        spare_reg <= s.data;
      end
      spare_v_reg <= spare_v_reg ? ~load : (take & ~load);
    end
  end
endmodule // dnconv_buf

// ---- dnconv_top.sv ----
// Down converter: channel swap, mixer, decimating filter, gain, quarter-rate mix
//
// Contract
// - Path is bypassed unless the software enable bit is set.
// - Complex mode mixes with a 32-bit oscillator, decimates by 2 to 32.
// - Real mode skips the mixer; filter is a low-pass decimator.
// - Filter arithmetic is 20 bits; the formatter truncates afterwards.
// - Optional swap routes each converter channel into the other filter.
// - Complex: shift by oscillator, low-pass around zero, then decimate.
// - Complex mode has a software-enabled 6 dB gain.
// - Real mode: no shift, real half only, rate is input over factor.
// - Real mode has a software-enabled 3 dB gain.
// - Quarter-rate mode mixes complex output with a quarter-rate tone.
// - Quarter-rate mode emits real words at twice the complex rate.
// - Frequency word is signed two's complement, minus to plus half rate.
// - New frequency applies only after restart bit or sync toggle; the code restarts on a rising sync edge only.
// - Software can invert the mixer phase to the conjugate tone.
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
module dnconv_top #(
  parameter int IN_W = dnconv_pkg::IN_W,
  parameter int DATA_W = dnconv_pkg::DATA_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [dnconv_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  // Converter samples
  input wire logic in_valid,
  input wire logic [IN_W-1:0] in_first,
  input wire logic [IN_W-1:0] in_second,
  input wire logic sync,
  // Output stream
  output logic out_valid,
  input wire logic out_ready,
  output logic out_real,
  output logic [DATA_W-1:0] out_first_i,
  output logic [DATA_W-1:0] out_first_q,
  output logic [DATA_W-1:0] out_second_i,
  output logic [DATA_W-1:0] out_second_q
);
  import dnconv_pkg::*;

  localparam int SH = DATA_W - IN_W;
  localparam int ACC_W = DATA_W + 5;
  localparam int BUF_W = 4 * DATA_W + 1;

  if (SH < 1 || SH > 15) begin : g_check
    $error("dnconv_top: DATA_W - IN_W must lie in 1..15");
  end

  // Reset release
  logic [1:0] rst_sync_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  wire logic rst_n = rst_sync_reg[1];

  // Arithmetic helpers
  function automatic logic [2:0] dec_log2(input logic [2:0] code);
    return (code > DEC_MAX_CODE) ? 3'h5 : code + 3'h1;
  endfunction

  function automatic logic signed [DATA_W-1:0] sat(
      input logic signed [DATA_W+1:0] v);
    logic signed [DATA_W+1:0] hi;
    logic signed [DATA_W+1:0] lo;
    hi = {3'b000, {(DATA_W-1){1'b1}}};
    lo = {3'b111, {(DATA_W-1){1'b0}}};
    if (v > hi) begin
      return hi[DATA_W-1:0];
    end else if (v < lo) begin
      return lo[DATA_W-1:0];
    end
    return v[DATA_W-1:0];
  endfunction

  function automatic logic signed [DATA_W-1:0] neg(
      input logic signed [DATA_W-1:0] y);
    return sat(-{{2{y[DATA_W-1]}}, y});
  endfunction

  function automatic logic signed [DATA_W-1:0] scale(
      input logic signed [ACC_W-1:0] sum, input logic [2:0] k);
    logic signed [ACC_W-1:0] t;
    t = sum >>> k;
    return t[DATA_W-1:0];
  endfunction

  // Gain of 2 for complex, about 1.41 for real
  function automatic logic signed [DATA_W-1:0] gain(
      input logic signed [DATA_W-1:0] y, input logic on, input logic is_real);
    logic signed [DATA_W+1:0] e;
    logic signed [DATA_W+1:0] v;
    e = {{2{y[DATA_W-1]}}, y};
    v = e;
    if (on && is_real) begin
      v = e + (e >>> 2) + (e >>> 3) + (e >>> 5);
    end else if (on) begin
      v = e <<< 1;
    end
    return sat(v);
  endfunction

  // Registers
  logic [31:0] ctrl_reg;
  logic [31:0] freq_reg;
  logic [31:0] rdata_reg;
  logic ovf_reg;
  logic restart_q_reg;
  logic sync_q_reg;

  wire logic en = ctrl_reg[CTRL_EN];
  wire logic real_sel = ctrl_reg[CTRL_REAL];
  wire logic gain_on = ctrl_reg[CTRL_GAIN];
  wire logic fs4_on = ctrl_reg[CTRL_FS4];
  wire logic swap = ctrl_reg[CTRL_SWAP];
  wire logic invert = ctrl_reg[CTRL_INV];
  wire logic [2:0] dec_code = ctrl_reg[CTRL_DEC_LSB +: 3];
  wire logic [2:0] k = dec_log2(dec_code);
  wire logic [4:0] n_last = 5'((6'h01 << k) - 6'h01);

  dnconv_mode_t mode;
  assign mode = !en ? DN_BYPASS : real_sel ? DN_REAL : fs4_on ? DN_FS4 : DN_COMPLEX;
  wire logic cplx = (mode == DN_COMPLEX) || (mode == DN_FS4);

  wire logic wr_ctrl = wr && (addr == OFF_CTRL);
  wire logic wr_freq = wr && (addr == OFF_FREQ);
  wire logic wr_status = wr && (addr == OFF_STATUS);
  wire logic restart_rise = ctrl_reg[CTRL_RESTART] & ~restart_q_reg;
  wire logic sync_rise = sync & ~sync_q_reg;
  wire logic restart = restart_rise | sync_rise;

  // Streams around the buffer
  dnconv_if #(.W(BUF_W)) push_if ();
  dnconv_if #(.W(BUF_W)) pop_if ();

  logic pend_reg;
  logic ph_reg;
  logic [4:0] dcnt_reg;
  logic [BUF_W-1:0] pend_word_reg;

  // A full buffer or an unsent second word stalls; samples then are dropped
  wire logic stall = pend_reg | ~push_if.ready;
  wire logic take = in_valid & ~stall;
  wire logic drop = in_valid & stall;
  wire logic dump = take && en && (dcnt_reg == n_last);

  // Channel swap
  logic signed [IN_W-1:0] src [2];
  assign src[0] = swap ? in_second : in_first;
  assign src[1] = swap ? in_first : in_second;

  // Oscillator
  logic signed [LUT_W-1:0] cos_w;
  logic signed [LUT_W-1:0] sin_w;
  logic [FREQ_W-1:0] freq_act;

  dnconv_nco u_nco (
    .clk(clk),
    .rst_n(rst_n),
    .step(take & cplx),
    .restart(restart),
    .invert(invert),
    .freq_new(freq_reg),
    .freq_act(freq_act),
    .cos_out(cos_w),
    .sin_out(sin_w)
  );

  // Mixer and accumulate-and-dump low-pass per channel
  logic signed [DATA_W-1:0] wide [2];
  logic signed [DATA_W-1:0] mix_i [2];
  logic signed [DATA_W-1:0] mix_q [2];
  logic signed [ACC_W-1:0] sum_i [2];
  logic signed [ACC_W-1:0] sum_q [2];
  logic signed [ACC_W-1:0] acc_i_reg [2];
  logic signed [ACC_W-1:0] acc_q_reg [2];
  logic signed [DATA_W-1:0] res_i [2];
  logic signed [DATA_W-1:0] res_q [2];

  for (genvar c = 0; c < 2; c++) begin : g_ch
    wire logic signed [IN_W+15:0] prod_i = src[c] * cos_w;
    wire logic signed [IN_W+15:0] prod_q = src[c] * sin_w;
    assign wide[c] = {src[c], {SH{1'b0}}};
    // Mixer product rescaled into the 20-bit working range
    assign mix_i[c] = cplx ? DATA_W'(prod_i >>> (15 - SH)) : wide[c];
    assign mix_q[c] = cplx ? DATA_W'(prod_q >>> (15 - SH)) : '0;
    assign sum_i[c] = acc_i_reg[c] + ACC_W'(mix_i[c]);
    assign sum_q[c] = acc_q_reg[c] + ACC_W'(mix_q[c]);
    assign res_i[c] = gain(scale(sum_i[c], k), gain_on, real_sel);
    assign res_q[c] = gain(scale(sum_q[c], k), gain_on, real_sel);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < 2; c++) begin
        acc_i_reg[c] <= '0;
        acc_q_reg[c] <= '0;
      end
      dcnt_reg <= '0;
    end else if (restart || !en) begin
      for (int c = 0; c < 2; c++) begin
        acc_i_reg[c] <= '0;
        acc_q_reg[c] <= '0;
      end
      dcnt_reg <= '0;
    end else if (take) begin
      for (int c = 0; c < 2; c++) begin
        acc_i_reg[c] <= dump ? '0 : sum_i[c];
        acc_q_reg[c] <= dump ? '0 : sum_q[c];
      end
      dcnt_reg <= dump ? 5'h00 : dcnt_reg + 5'h01;
    end
  end

  // Word forming; quarter-rate sequence is I, -Q, -I, Q
  wire logic [DATA_W-1:0] zero_w = '0;
  logic [BUF_W-1:0] word_now;
  logic [BUF_W-1:0] word_second;

  always_comb begin
    word_second = {1'b1, neg(res_q[0]), zero_w, neg(res_q[1]), zero_w};
    if (ph_reg) begin
      word_second = {1'b1, res_q[0], zero_w, res_q[1], zero_w};
    end
    unique case (mode)
      DN_BYPASS: word_now = {1'b1, wide[0], zero_w, wide[1], zero_w};
      DN_COMPLEX: word_now = {1'b0, res_i[0], res_q[0], res_i[1], res_q[1]};
      DN_REAL: word_now = {1'b1, res_i[0], zero_w, res_i[1], zero_w};
      DN_FS4: begin
        if (ph_reg) begin
          word_now = {1'b1, neg(res_i[0]), zero_w, neg(res_i[1]), zero_w};
        end else begin
          word_now = {1'b1, res_i[0], zero_w, res_i[1], zero_w};
        end
      end
    endcase
  end

  wire logic push_now = (mode == DN_BYPASS) ? take : dump;
  assign push_if.valid = push_now | pend_reg;
  assign push_if.data = pend_reg ? pend_word_reg : word_now;

  // Second real word of a quarter-rate pair
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 1'b0;
      ph_reg <= 1'b0;
      pend_word_reg <= '0;
    end else if (restart) begin
      pend_reg <= 1'b0;
      ph_reg <= 1'b0;
    end else if (pend_reg) begin
      pend_reg <= ~push_if.ready;
    end else if (dump && mode == DN_FS4) begin
      pend_reg <= 1'b1;
      pend_word_reg <= word_second;
      ph_reg <= ~ph_reg;
    end
  end

  dnconv_buf #(.W(BUF_W)) u_buf (
    .clk(clk),
    .rst_n(rst_n),
    .s(push_if.snk),
    .m(pop_if.src)
  );

  assign pop_if.ready = out_ready;
  assign out_valid = pop_if.valid;
  assign out_real = pop_if.data[BUF_W-1];
  assign out_first_i = pop_if.data[3*DATA_W +: DATA_W];
  assign out_first_q = pop_if.data[2*DATA_W +: DATA_W];
  assign out_second_i = pop_if.data[DATA_W +: DATA_W];
  assign out_second_q = pop_if.data[0 +: DATA_W];

  // Register file
  logic [31:0] status_w;
  logic [31:0] rd_mux;
  assign status_w = {28'h0, en, ~push_if.ready, pend_reg, ovf_reg};

  always_comb begin
    unique case (addr)
      OFF_CTRL: rd_mux = ctrl_reg;
      OFF_FREQ: rd_mux = freq_reg;
      OFF_STATUS: rd_mux = status_w;
      OFF_FREQ_ACT: rd_mux = freq_act;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= CTRL_RESET;
      freq_reg <= FREQ_RESET;
      rdata_reg <= 32'h0000_0000;
      ovf_reg <= 1'b0;
      restart_q_reg <= 1'b0;
      sync_q_reg <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= wdata & CTRL_MASK;
      end
      if (wr_freq) begin
        freq_reg <= wdata;
      end
      // A drop in the clearing cycle keeps the flag set
      ovf_reg <= drop | (ovf_reg & ~(wr_status & wdata[ST_OVF]));
      rdata_reg <= rd ? rd_mux : 32'h0000_0000;
      restart_q_reg <= ctrl_reg[CTRL_RESTART];
      sync_q_reg <= sync;
    end
  end

  assign rdata = rdata_reg;
endmodule // dnconv_top

// ---- dnconv_checker.sv ----
// Port checker of the down converter, bound to its top module
`timescale 1ns/100ps
module dnconv_checker #(
  parameter int IN_W = 16,
  parameter int DATA_W = 20
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register port
  input wire logic [dnconv_pkg::ADDR_W-1:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  // Samples
  input wire logic in_valid,
  input wire logic [IN_W-1:0] in_first,
  input wire logic [IN_W-1:0] in_second,
  input wire logic sync,
  // Output stream
  input wire logic out_valid,
  input wire logic out_ready,
  input wire logic out_real,
  input wire logic [DATA_W-1:0] out_first_i,
  input wire logic [DATA_W-1:0] out_first_q,
  input wire logic [DATA_W-1:0] out_second_i,
  input wire logic [DATA_W-1:0] out_second_q
);
  import dnconv_pkg::*;
  logic [31:0] ctrl_reg, ctrl_next, freq_reg, freq_next, act_reg, act_next;
  logic [1:0] quiet_reg, quiet_next;
  logic sync_reg, kick, cplx;
  logic [DATA_W-1:0] pass_a, pass_b;
  // Restart: control bit rising or sync rising
  assign kick = (wr && addr == OFF_CTRL && wdata[CTRL_RESTART] && !ctrl_reg[CTRL_RESTART])
    || (sync && !sync_reg);
  assign ctrl_next = (wr && addr == OFF_CTRL) ? wdata : ctrl_reg;
  assign freq_next = (wr && addr == OFF_FREQ) ? wdata : freq_reg;
  assign act_next = kick ? freq_reg : act_reg;
  assign quiet_next = kick ? 2'h0 : (quiet_reg == 2'h3) ? 2'h3 : quiet_reg + 2'h1;
  assign cplx = ctrl_reg[CTRL_EN] && !ctrl_reg[CTRL_REAL] && !ctrl_reg[CTRL_FS4];
  assign pass_a = DATA_W'(signed'(ctrl_reg[CTRL_SWAP] ? in_second : in_first)) << 4;
  assign pass_b = DATA_W'(signed'(ctrl_reg[CTRL_SWAP] ? in_first : in_second)) << 4;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_reg <= CTRL_RESET;
      freq_reg <= FREQ_RESET;
      act_reg <= FREQ_RESET;
      quiet_reg <= 2'h3;
      sync_reg <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      freq_reg <= freq_next;
      act_reg <= act_next;
      quiet_reg <= quiet_next;
      sync_reg <= sync;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  chk_rdata_idle: assert property (!rd |=> rdata == 32'h0)
    else $error("read data not zero outside a read");
  chk_ctrl_back: assert property (rd && addr == OFF_CTRL |=> rdata == (ctrl_reg & CTRL_MASK))
    else $error("control readback wrong");
  chk_freq_back: assert property (rd && addr == OFF_FREQ |=> rdata == freq_reg)
    else $error("frequency readback wrong");
  chk_act_freq: assert property (rd && addr == OFF_FREQ_ACT && quiet_reg == 2'h3
    |=> rdata == act_reg) else $error("active frequency wrong");
  chk_bypass_word: assert property (!ctrl_reg[CTRL_EN] && in_valid && !out_valid
    |=> out_valid && out_real && out_first_i == $past(pass_a) && out_second_i == $past(pass_b))
    else $error("bypass word wrong");
  chk_word_hold: assert property (out_valid && !out_ready
    |=> out_valid && $stable(out_first_i) && $stable(out_second_i) && $stable(out_real))
    else $error("word changed while stalled");
  chk_real_qzero: assert property (out_valid && out_real
    |-> out_first_q == '0 && out_second_q == '0) else $error("real word has quadrature");
  chk_mode_flag: assert property ($rose(out_valid) && $stable(ctrl_reg)
    |-> out_real == !cplx) else $error("real flag does not match mode");
  cov_fs4: cover property (out_valid && out_real && ctrl_reg[CTRL_FS4] && ctrl_reg[CTRL_EN]);
  cov_stall: cover property (in_valid && out_valid && !out_ready);
  cov_kick: cover property (kick);
endmodule // dnconv_checker

bind dnconv_top dnconv_checker #(.IN_W(IN_W), .DATA_W(DATA_W)) i_dnconv_checker (.clk(clk),
  .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .in_valid(in_valid), .in_first(in_first), .in_second(in_second), .sync(sync),
  .out_valid(out_valid), .out_ready(out_ready), .out_real(out_real),
  .out_first_i(out_first_i), .out_first_q(out_first_q), .out_second_i(out_second_i),
  .out_second_q(out_second_q));

// ---- dnconv_sink.sv ----
// Output formatter model: takes words promptly, slowly or not at all
`timescale 1ns/100ps
module dnconv_sink (
  // Clock
  input wire logic clk,
  // Output stream
  input wire logic out_valid,
  output logic out_ready,
  input wire logic [4*dnconv_pkg::DATA_W:0] word,
  // Pace: 0 prompt, 1 every other cycle, 2 stalled
  input wire logic [1:0] stall
);
  import dnconv_pkg::*;
  logic [4*DATA_W:0] q[$];
  logic tog = 1'b0;
  assign out_ready = (stall == 2'h0) || (stall == 2'h1 && tog);
  always @(posedge clk) begin
    tog <= ~tog;
    if (out_valid && out_ready) begin
      q.push_back(word);
    end
  end
endmodule // dnconv_sink

// ---- dnconv_tb.sv ----
// Self-checking bench of the down converter
`timescale 1ns/100ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("CHECK FAILED %0t got %h exp %h", $time, a, b); end end
module dnconv_tb;
  import dnconv_pkg::*;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [ADDR_W-1:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic in_valid = 1'b0;
  logic [IN_W-1:0] in_first = 16'h0;
  logic [IN_W-1:0] in_second = 16'h0;
  logic sync = 1'b0;
  logic [1:0] stall = 2'h1;
  logic [31:0] rdata;
  logic out_valid, out_ready, out_real;
  logic [DATA_W-1:0] fi, fq, si, sq, q0;
  logic [4*DATA_W:0] w;
  int n_fail = 0;
  int total_checks = 0;
  int seed = 78;
  int cyc = 0;
  int sa, sb;
  int gx[3] = '{1024, 32767, -32768};
  int fx[4] = '{65534, 0, -65534, 0};
  always #25 clk = ~clk;
  dnconv_top i_dnconv_top (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .in_valid(in_valid), .in_first(in_first), .in_second(in_second),
    .sync(sync), .out_valid(out_valid), .out_ready(out_ready), .out_real(out_real),
    .out_first_i(fi), .out_first_q(fq), .out_second_i(si), .out_second_q(sq));
  dnconv_sink i_dnconv_sink (.clk(clk), .out_valid(out_valid), .out_ready(out_ready),
    .word({out_real, sq, fq, fi, si}), .stall(stall));
  function automatic logic [19:0] sat(input longint v);
    return (v > 524287) ? 20'h7ffff : (v < -524288) ? 20'h80000 : 20'(v);
  endfunction
  function automatic longint g3(input longint y);
    return y + (y >>> 2) + (y >>> 3) + (y >>> 5);
  endfunction
  task automatic wreg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    `CHK(rdata, e)
  endtask
  // Mode change always ends with a restart edge
  task automatic set(input logic [31:0] c);
    wreg(OFF_CTRL, c);
    wreg(OFF_CTRL, c | 32'h200);
    repeat (3) @(posedge clk);
  endtask
  task automatic grp(input logic [15:0] a, input logic [15:0] b, input int n, input bit rnd);
    sa = 0;
    sb = 0;
    repeat (n) begin
      @(posedge clk);
      if (rnd) begin
        a = 16'($random(seed));
        b = 16'($random(seed));
      end
      in_valid <= 1'b1;
      in_first <= a;
      in_second <= b;
      sa += int'($signed(a));
      sb += int'($signed(b));
    end
    repeat (6) @(posedge clk) in_valid <= 1'b0;
  endtask
  task automatic get();
    int t;
    t = 0;
    while (i_dnconv_sink.q.size() == 0 && t < 400) begin
      @(negedge clk);
      t++;
    end
    w = (t < 400) ? i_dnconv_sink.q.pop_front() : '1;
  endtask
  task automatic cw(input logic r, input logic [19:0] i, input logic [19:0] s,
    input logic [19:0] q);
    get();
    `CHK(w[80], r)
    `CHK(w[39:20], i)
    `CHK(w[19:0], s)
    `CHK(w[59:40], q)
    `CHK(w[79:60], q)
  endtask
  task automatic done(input string s);
    $display("test %s done", s);
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      end_sim();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    for (int k = 0; k < 16; k += 2) rreg(4'(k), 32'h0);
    wreg(4'h2, 32'hffffffff);
    wreg(OFF_CTRL, 32'hffffffff);
    rreg(OFF_CTRL, CTRL_MASK);
    rreg(4'h2, 32'h0);
    done("registers");
    for (int s = 0; s < 2; s++) begin
      set(s ? 32'h80 : 32'h0);
      grp(16'h0, 16'h0, 1, 1);
      cw(1'b1, sat(16 * (s ? sb : sa)), sat(16 * (s ? sa : sb)), 20'h0);
    end
    done("bypass");
    // Code 7 lies above the largest factor and must act as 32
    for (int c = 0; c < 6; c++) begin
      int lg;
      lg = (c == 5) ? 5 : c + 1;
      set(32'h3 | (((c == 5) ? 7 : c) << CTRL_DEC_LSB));
      repeat (3) begin
        grp(16'h0, 16'h0, 1 << lg, 1);
        cw(1'b1, sat((sa * 16) >>> lg), sat((sb * 16) >>> lg), 20'h0);
      end
    end
    set(32'h23);
    for (int k = 0; k < 3; k++) begin
      grp(16'(gx[k]), 16'(gx[k]), 2, 0);
      cw(1'b1, sat(g3(gx[k] * 16)), sat(g3(gx[k] * 16)), 20'h0);
    end
    done("real");
    for (int c = 0; c < 5; c++) begin
      set(32'h1 | (c << CTRL_DEC_LSB));
      grp(16'h1000, 16'h1000, 2 << c, 0);
      cw(1'b0, 20'h0fffe, 20'h0fffe, 20'h0);
    end
    set(32'h21);
    grp(16'h1000, 16'h1000, 2, 0);
    cw(1'b0, 20'h1fffc, 20'h1fffc, 20'h0);
    done("complex");
    wreg(OFF_CTRL, 32'h1);
    wreg(OFF_FREQ, 32'h80000000);
    rreg(OFF_FREQ_ACT, 32'h0);
    grp(16'h1000, 16'h1000, 2, 0);
    cw(1'b0, 20'h0fffe, 20'h0fffe, 20'h0);
    set(32'h1);
    rreg(OFF_FREQ_ACT, 32'h80000000);
    grp(16'h1000, 16'h1000, 2, 0);
    cw(1'b0, 20'h0, 20'h0, 20'h0);
    wreg(OFF_FREQ, 32'h40000000);
    @(posedge clk) sync <= 1'b1;
    @(posedge clk) sync <= 1'b0;
    repeat (3) @(posedge clk);
    rreg(OFF_FREQ_ACT, 32'h40000000);
    set(32'h1);
    grp(16'h1000, 16'h1000, 2, 0);
    get();
    q0 = w[59:40];
    set(32'h101);
    grp(16'h1000, 16'h1000, 2, 0);
    get();
    `CHK(w[59:40], -q0)
    `CHK(q0 != 20'h0, 1'b1)
    done("oscillator");
    wreg(OFF_FREQ, 32'h0);
    set(32'h41);
    grp(16'h1000, 16'h1000, 2, 0);
    grp(16'h1000, 16'h1000, 2, 0);
    for (int k = 0; k < 4; k++) cw(1'b1, 20'(fx[k]), 20'(fx[k]), 20'h0);
    done("quarter rate");
    set(32'h0);
    stall <= 2'h2;
    grp(16'h0011, 16'h0022, 1, 0);
    grp(16'h0033, 16'h0044, 1, 0);
    grp(16'h0055, 16'h0066, 2, 0);
    rreg(OFF_STATUS, 32'h5);
    stall <= 2'h1;
    cw(1'b1, 20'h00110, 20'h00220, 20'h0);
    cw(1'b1, 20'h00330, 20'h00440, 20'h0);
    repeat (8) @(posedge clk);
    `CHK(i_dnconv_sink.q.size(), 0)
    wreg(OFF_STATUS, 32'h1);
    rreg(OFF_STATUS, 32'h0);
    done("stall");
    end_sim();
  end
endmodule // dnconv_tb
